// ==== core/core_regs_pkg.sv ====
// package: offsets, field positions, reset values and carrier types for the core register bank
package core_regs_pkg;

   // register word offsets (byte address = 4 * index)
   localparam logic [1:0] IDX_FLAGS   = 2'h0;
   localparam logic [1:0] IDX_OPTIONS = 2'h1;
   localparam logic [1:0] IDX_INTCTL  = 2'h2;

   // flags register fields
   localparam int FLD_CARRY    = 0;
   localparam int FLD_NIBBLE   = 1;
   localparam int FLD_ZERO     = 2;
   localparam int FLD_SLEEP    = 3;
   localparam int FLD_WDOG     = 4;
   localparam int FLD_DBANK_LO = 5;
   localparam int FLD_IBANK    = 7;

   // option register fields
   localparam int FLD_RATE_LO  = 0;
   localparam int FLD_OWNER    = 3;
   localparam int FLD_T0EDGE   = 4;
   localparam int FLD_T0SRC    = 5;
   localparam int FLD_EXTEDGE  = 6;
   localparam int FLD_PULLUP   = 7;

   // interrupt control fields
   localparam int FLD_PBFLAG   = 0;
   localparam int FLD_EXTFLAG  = 1;
   localparam int FLD_T0FLAG   = 2;
   localparam int FLD_PBEN     = 3;
   localparam int FLD_EXTEN    = 4;
   localparam int FLD_T0EN     = 5;
   localparam int FLD_PERIEN   = 6;
   localparam int FLD_GLOBEN   = 7;

   // values after reset
   localparam logic [7:0] RST_FLAGS   = 8'h18;
   localparam logic [7:0] RST_OPTIONS = 8'hff;
   localparam logic [7:0] RST_INTCTL  = 8'h00;

   // alu operation kinds reported by the core
   typedef enum logic [2:0] {
      ALU_NONE  = 3'b000,
      ALU_LOGIC = 3'b001,
      ALU_ADD   = 3'b010,
      ALU_SUB   = 3'b011,
      ALU_RLC   = 3'b100,
      ALU_RRC   = 3'b101
   } aluOp_t;

   typedef struct packed {
      aluOp_t     op;
      logic [7:0] a;
      logic [7:0] b;
   } aluReq_t;

   typedef struct packed {
      logic [7:0] result;
      logic       zero;
      logic       nibble;
      logic       carry;
   } aluRes_t;

   typedef struct packed {
      logic       timer0Source;
      logic       timer0Edge;
      logic       prescalerOwner;
      logic [8:0] timer0Divide;
      logic [7:0] watchdogDivide;
   } timerCfg_t;

   typedef struct packed {
      logic [1:0] rstSync;
      logic [7:0] flags;
      logic [7:0] options;
      logic [7:0] intctl;
      logic [7:0] previousPins;
      logic [2:0] extSync;
      logic [7:0] pinSync1;
      logic [7:0] pinSync2;
      logic       waitReq;
      logic [7:0] readData;
      logic       irq;
      logic [7:0] pullupEnable;
      aluRes_t    alu;
      timerCfg_t  timerCfg;
      logic [8:0] directBase;
      logic [8:0] indirectBase;
   } state_t;

endpackage : core_regs_pkg

// ==== core/core_status_option_interrupt_regs.sv ====
// core flags, option and interrupt control registers with an avalon-mm slave
//
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps

module core_status_option_interrupt_regs
   import core_regs_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // avalon-mm slave
   input  wire logic [3:0] address,
   input  wire logic       read,
   input  wire logic       write,
   input  wire logic [31:0] writedata,
   output logic      [31:0] readdata,
   output logic            waitrequest,
   // instruction core
   input  wire aluReq_t    aluReq,
   input  wire logic       watchdogClear,
   input  wire logic       sleepExecute,
   input  wire logic       watchdogTimeout,
   input  wire logic       timer0Rollover,
   input  wire logic       peripheralRequest,
   output aluRes_t         aluResult,
   output logic      [8:0] directBankBase,
   output logic      [8:0] indirectBankBase,
   output timerCfg_t       timerConfig,
   output logic            interruptRequest,
   // port and pins
   input  wire logic       extIrqPin,
   input  wire logic [7:0] portbPins,
   input  wire logic [7:0] perPinChangeEnables,
   input  wire logic [7:0] pullupLatchEnables,
   input  wire logic       ultraLowPowerWakeup,
   output logic      [7:0] pullupEnable
);

   state_t st;
   state_t next_st;
   logic   rstSafe_n;

   // alu arithmetic: carry from a 9-bit add, nibble carry from a 5-bit add
   function automatic aluRes_t aluCompute(input aluReq_t r, input logic carryIn);
      logic [8:0] sum;
      logic [4:0] low;
      logic [7:0] addend;
      aluRes_t    res;
      sum    = 9'h000;
      low    = 5'h00;
      addend = (r.op == ALU_SUB) ? 8'((~r.b) + 8'h01) : r.b;
      res    = '0;
      case (r.op)
         ALU_ADD, ALU_SUB: begin
            sum        = {1'b0, r.a} + {1'b0, addend};
            low        = {1'b0, r.a[3:0]} + {1'b0, addend[3:0]};
            res.result = sum[7:0];
            res.carry  = sum[8] | ((r.op == ALU_SUB) && (r.b == 8'h00));
            res.nibble = low[4] | ((r.op == ALU_SUB) && (r.b[3:0] == 4'h0));
         end
         ALU_RLC: begin
            res.result = {r.a[6:0], carryIn};
            res.carry  = r.a[7];
         end
         ALU_RRC: begin
            res.result = {carryIn, r.a[7:1]};
            res.carry  = r.a[0];
         end
         default: begin
            res.result = r.a;
         end
      endcase
      res.zero = (res.result == 8'h00);
      return res;
   endfunction : aluCompute

   // timer0 prescaler ratio as 2**(rate+1), watchdog one step lower at 2**rate
   function automatic logic [7:0] pow2(input logic [2:0] e);
      return 8'(8'h01 << e);
   endfunction : pow2

   assign rstSafe_n = st.rstSync[1];

   always_comb begin
      logic    wr;
      logic    rd;
      logic [1:0] idx;
      logic    mapped;
      logic    extRise;
      logic    extFall;
      logic    extEdge;
      logic    pinChange;
      aluRes_t ar;
      logic [7:0] wd;
      wr        = 1'b0;
      rd        = 1'b0;
      idx       = 2'h0;
      mapped    = 1'b0;
      extRise   = 1'b0;
      extFall   = 1'b0;
      extEdge   = 1'b0;
      pinChange = 1'b0;
      ar        = '0;
      wd        = writedata[7:0];
      next_st   = st;
      next_st.rstSync = {st.rstSync[0], 1'b1};

      // one wait cycle per access, then answer
      idx    = address[3:2];
      mapped = (address[1:0] == 2'b00) && (idx != 2'h3);
      wr     = write && st.waitReq && rstSafe_n;
      rd     = read && st.waitReq && rstSafe_n;
      next_st.waitReq = !((read || write) && st.waitReq);

      // synchronised pins
      next_st.extSync  = {st.extSync[1:0], extIrqPin};
      next_st.pinSync1 = portbPins;
      next_st.pinSync2 = st.pinSync1;
      extRise = st.extSync[1] && !st.extSync[2];
      extFall = !st.extSync[1] && st.extSync[2];
      extEdge = st.options[FLD_EXTEDGE] ? extRise : extFall;
      pinChange = |((st.pinSync2 ^ st.previousPins) & perPinChangeEnables) | ultraLowPowerWakeup;
      next_st.previousPins = st.pinSync2;

      // software writes, before hardware events so the events win
      if (wr && mapped) begin
         case (idx)
            IDX_FLAGS: begin
               next_st.flags[FLD_IBANK]              = wd[FLD_IBANK];
               next_st.flags[FLD_DBANK_LO +: 2]      = wd[FLD_DBANK_LO +: 2];
               if (aluReq.op == ALU_NONE) begin
                  next_st.flags[FLD_ZERO]   = wd[FLD_ZERO];
                  next_st.flags[FLD_NIBBLE] = wd[FLD_NIBBLE];
                  next_st.flags[FLD_CARRY]  = wd[FLD_CARRY];
               end
               // watchdog and sleep bits are never taken from software
            end
            IDX_OPTIONS: next_st.options = wd;
            IDX_INTCTL:  next_st.intctl  = wd;
            default:     next_st.intctl  = st.intctl;
         endcase
      end

      // alu results override any write to the same bits
      if (aluReq.op != ALU_NONE) begin
         ar = aluCompute(aluReq, st.flags[FLD_CARRY]);
         next_st.flags[FLD_ZERO] = ar.zero;
         if (aluReq.op == ALU_ADD || aluReq.op == ALU_SUB) begin
            next_st.flags[FLD_NIBBLE] = ar.nibble;
         end
         if (aluReq.op != ALU_LOGIC) begin
            next_st.flags[FLD_CARRY] = ar.carry;
         end
      end
      next_st.alu = ar;

      // reset-status bits
      if (watchdogClear) begin
         next_st.flags[FLD_WDOG]  = 1'b1;
         next_st.flags[FLD_SLEEP] = 1'b1;
      end else if (sleepExecute) begin
         next_st.flags[FLD_WDOG]  = 1'b1;
         next_st.flags[FLD_SLEEP] = 1'b0;
      end
      if (watchdogTimeout) begin
         next_st.flags[FLD_WDOG] = 1'b0;
      end

      // sticky flags regardless of enables, set beats clear
      if (timer0Rollover) next_st.intctl[FLD_T0FLAG] = 1'b1;
      if (extEdge)        next_st.intctl[FLD_EXTFLAG] = 1'b1;
      if (pinChange)      next_st.intctl[FLD_PBFLAG] = 1'b1;

      // request to the core
      next_st.irq = (st.intctl[FLD_GLOBEN] &&
                     ((st.intctl[FLD_T0EN] && st.intctl[FLD_T0FLAG]) ||
                      (st.intctl[FLD_EXTEN] && st.intctl[FLD_EXTFLAG]) ||
                      (st.intctl[FLD_PBEN] && st.intctl[FLD_PBFLAG]))) ||
                    (st.intctl[FLD_GLOBEN] && st.intctl[FLD_PERIEN] && peripheralRequest);

      // configuration outputs
      next_st.pullupEnable = st.options[FLD_PULLUP] ? 8'h00 : pullupLatchEnables;
      next_st.timerCfg.timer0Source   = st.options[FLD_T0SRC];
      next_st.timerCfg.timer0Edge     = st.options[FLD_T0EDGE];
      next_st.timerCfg.prescalerOwner = st.options[FLD_OWNER];
      next_st.timerCfg.timer0Divide   = st.options[FLD_OWNER] ? 9'h001
                                         : {pow2(st.options[FLD_RATE_LO +: 3]), 1'b0};
      next_st.timerCfg.watchdogDivide = st.options[FLD_OWNER] ? pow2(st.options[FLD_RATE_LO +: 3])
                                         : 8'h01;
      next_st.directBase   = {st.flags[FLD_DBANK_LO +: 2], 7'h00};
      next_st.indirectBase = {st.flags[FLD_IBANK], 8'h00};

      // read data
      if (rd) begin
         case (idx)
            IDX_FLAGS:   next_st.readData = st.flags;
            IDX_OPTIONS: next_st.readData = st.options;
            IDX_INTCTL:  next_st.readData = st.intctl;
            default:     next_st.readData = 8'h00;
         endcase
         if (!mapped) next_st.readData = 8'h00;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st              <= '0;
         st.flags        <= RST_FLAGS;
         st.options      <= RST_OPTIONS;
         st.intctl       <= RST_INTCTL;
         st.waitReq      <= 1'b1;
         st.pullupEnable <= 8'h00;
      end else begin
         st <= next_st;
         if (!rstSafe_n) begin
            st.flags        <= RST_FLAGS;
            st.options      <= RST_OPTIONS;
            st.intctl       <= RST_INTCTL;
            st.waitReq      <= 1'b1;
            st.previousPins <= st.previousPins;
         end
      end
   end

   assign readdata         = {24'h000000, st.readData};
   assign waitrequest      = st.waitReq;
   assign aluResult        = st.alu;
   assign directBankBase   = st.directBase;
   assign indirectBankBase = st.indirectBase;
   assign timerConfig      = st.timerCfg;
   assign interruptRequest = st.irq;
   assign pullupEnable     = st.pullupEnable;

endmodule : core_status_option_interrupt_regs

// ==== tb/core_partner.sv ====
// behavioural instruction core: alu requests and one-cycle event pulses
`timescale 1ns/1ps
module core_partner
   import core_regs_pkg::*;
(
   input  wire logic clk,
   output aluReq_t   aluReq,
   output logic      watchdogClear,
   output logic      sleepExecute,
   output logic      watchdogTimeout,
   output logic      timer0Rollover,
   output logic      peripheralRequest
);
   logic [3:0] ev = 4'h0;
   initial aluReq = '0;
   initial peripheralRequest = 1'b0;
   assign {timer0Rollover, watchdogTimeout, sleepExecute, watchdogClear} = ev;
   task automatic doAlu(input aluOp_t op, input logic [7:0] a, input logic [7:0] b);
      @(posedge clk);
      aluReq <= '{op, a, b};
      @(posedge clk);
      aluReq <= '0;
   endtask : doAlu
   // kind 0 clear, 1 sleep, 2 timeout, 3 rollover
   task automatic pulse(input int kind);
      @(posedge clk);
      ev <= 4'h1 << kind;
      @(posedge clk);
      ev <= 4'h0;
   endtask : pulse
endmodule : core_partner

// ==== tb/core_status_option_interrupt_regs_asserts.sv ====
// port-level checks on the core register bank
`timescale 1ns/1ps
module core_status_option_interrupt_regs_asserts
   import core_regs_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        read,
   input wire logic        write,
   input wire logic [3:0]  address,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   input wire aluReq_t     aluReq,
   input wire aluRes_t     aluResult,
   input wire logic [8:0]  directBankBase,
   input wire logic [8:0]  indirectBankBase,
   input wire timerCfg_t   timerConfig,
   input wire logic [7:0]  pullupLatchEnables,
   input wire logic [7:0]  pullupEnable
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic [8:0] sumAdd;
   logic [8:0] sumSub;
   logic [4:0] nibAdd;
   logic [4:0] nibSub;
   assign sumAdd = {1'b0, aluReq.a} + {1'b0, aluReq.b};
   assign sumSub = {1'b0, aluReq.a} + {1'b0, ~aluReq.b} + 9'h001;
   assign nibAdd = {1'b0, aluReq.a[3:0]} + {1'b0, aluReq.b[3:0]};
   assign nibSub = {1'b0, aluReq.a[3:0]} + {1'b0, ~aluReq.b[3:0]} + 5'h01;
   sequence accessSeen;
      (read || write) && waitrequest;
   endsequence
   chk_wait_answer: assert property (accessSeen |=> !waitrequest) else $error("bus not answered");
   chk_wait_single: assert property (!waitrequest |=> waitrequest) else $error("answer too long");
   chk_add_flags: assert property (aluReq.op == ALU_ADD |=> aluResult == {$past(sumAdd[7:0]),
      $past(sumAdd[7:0]) == 8'h00, $past(nibAdd[4]), $past(sumAdd[8])}) else $error("add result wrong");
   chk_sub_flags: assert property (aluReq.op == ALU_SUB |=> aluResult == {$past(sumSub[7:0]),
      $past(sumSub[7:0]) == 8'h00, $past(nibSub[4]), $past(sumSub[8])}) else $error("sub result wrong");
   chk_rot_left: assert property (aluReq.op == ALU_RLC |=> aluResult.carry == $past(aluReq.a[7]))
      else $error("left rotate carry wrong");
   chk_rot_right: assert property (aluReq.op == ALU_RRC |=> aluResult.carry == $past(aluReq.a[0]))
      else $error("right rotate carry wrong");
   chk_bank_map: assert property (read && !waitrequest && address[3:2] == IDX_FLAGS |->
      directBankBase == {readdata[6:5], 7'h00} && indirectBankBase == {readdata[7], 8'h00})
      else $error("bank base mismatch");
   chk_pullup_mask: assert property (pullupEnable != 8'h00 |-> pullupEnable == $past(pullupLatchEnables))
      else $error("pullup not latch");
   chk_div_owner: assert property (timerConfig.prescalerOwner |-> timerConfig.timer0Divide == 9'h001)
      else $error("timer0 divided");
endmodule : core_status_option_interrupt_regs_asserts

// ==== tb/core_status_option_interrupt_regs_test.sv ====
// self-checking bench for the core flags, option and interrupt registers
`timescale 1ns/1ps
module core_status_option_interrupt_regs_test;
   import core_regs_pkg::*;
   logic clk = 1'b0, reset_n = 1'b0, read = 1'b0, write = 1'b0, waitrequest, extIrqPin = 1'b0;
   logic [3:0] address = 4'h0;
   logic [31:0] writedata = 32'h0, readdata;
   aluReq_t aluReq;
   aluRes_t aluResult;
   timerCfg_t timerConfig;
   logic watchdogClear, sleepExecute, watchdogTimeout, timer0Rollover, peripheralRequest, interruptRequest;
   logic [8:0] directBankBase, indirectBankBase;
   logic [7:0] portbPins = 8'h00, perPinChangeEnables = 8'hff, pullupLatchEnables = 8'h5a, pullupEnable, rd;
   logic ultraLowPowerWakeup = 1'b0;
   int errCount = 0, numChecks = 0, cycles = 0;
   core_status_option_interrupt_regs i_core_status_option_interrupt_regs (.clk, .reset_n, .address, .read,
      .write, .writedata, .readdata, .waitrequest, .aluReq, .watchdogClear, .sleepExecute, .watchdogTimeout,
      .timer0Rollover, .peripheralRequest, .aluResult, .directBankBase, .indirectBankBase, .timerConfig,
      .interruptRequest, .extIrqPin, .portbPins, .perPinChangeEnables, .pullupLatchEnables,
      .ultraLowPowerWakeup, .pullupEnable);
   core_partner i_core_partner (.clk, .aluReq, .watchdogClear, .sleepExecute, .watchdogTimeout,
      .timer0Rollover, .peripheralRequest);
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         errCount++;
         printVerdict();
      end
   end
   task automatic printVerdict();
      $display("checks %0d mismatches %0d", numChecks, errCount);
      if (errCount == 0 && numChecks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : printVerdict
   task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
      numChecks++;
      if (g !== e) begin
         errCount++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask : check
   task automatic acc(input logic wr, input logic [1:0] idx, input logic [7:0] wd);
      @(posedge clk);
      address <= {idx, 2'b00};
      write <= wr;
      read <= !wr;
      writedata <= {24'h0, wd};
      do @(posedge clk); while (waitrequest !== 1'b0);
      rd = readdata[7:0];
      read <= 1'b0;
      write <= 1'b0;
   endtask : acc
   task automatic rdChk(input string n, input logic [1:0] idx, input logic [7:0] e);
      acc(1'b0, idx, 8'h00);
      check(n, e, rd);
   endtask : rdChk
   task automatic testRegs();
      rdChk("flags", IDX_FLAGS, RST_FLAGS);
      rdChk("options", IDX_OPTIONS, RST_OPTIONS);
      rdChk("intctl", IDX_INTCTL, RST_INTCTL);
      acc(1'b1, 2'h3, 8'hff);
      rdChk("unmapped", 2'h3, 8'h00);
      acc(1'b1, IDX_FLAGS, 8'h07);
      rdChk("flagwr", IDX_FLAGS, 8'h1f);
      for (int i = 0; i < 8; i++) begin
         acc(1'b1, IDX_FLAGS, {i[2:0], 5'h00});
         repeat (2) @(negedge clk);
         check("dbank", {i[1:0], 7'h00}, directBankBase);
         check("ibank", {i[2], 8'h00}, indirectBankBase);
      end
      $display("registers done");
   endtask : testRegs
   task automatic testCore();
      aluOp_t op[6] = '{ALU_ADD, ALU_ADD, ALU_SUB, ALU_SUB, ALU_RLC, ALU_RRC};
      logic [7:0] av[6] = '{8'h0f, 8'hff, 8'h05, 8'h00, 8'h80, 8'h01};
      logic [7:0] bv[6] = '{8'h01, 8'h01, 8'h05, 8'h01, 8'h00, 8'h00};
      logic [10:0] ev[6] = '{11'h082, 11'h007, 11'h007, 11'h7f8, 11'h001, 11'h001};
      logic [10:0] mv[6] = '{11'h7ff, 11'h7ff, 11'h7ff, 11'h7ff, 11'h001, 11'h001};
      i_core_partner.pulse(1);
      rdChk("sleep", IDX_FLAGS, 8'hf0);
      i_core_partner.pulse(2);
      rdChk("timeout", IDX_FLAGS, 8'he0);
      i_core_partner.pulse(1);
      rdChk("sleep2", IDX_FLAGS, 8'hf0);
      i_core_partner.pulse(0);
      rdChk("wdclear", IDX_FLAGS, 8'hf8);
      for (int i = 0; i < 6; i++) begin
         i_core_partner.doAlu(op[i], av[i], bv[i]);
         @(negedge clk);
         check("alu", ev[i], aluResult & mv[i]);
      end
      acc(1'b1, IDX_FLAGS, 8'he0);
      fork
         acc(1'b1, IDX_FLAGS, 8'he3);
         i_core_partner.doAlu(ALU_LOGIC, 8'h00, 8'h00);
      join
      rdChk("aluwins", IDX_FLAGS, 8'hfc);
      $display("core done");
   endtask : testCore
   task automatic testOptions();
      for (int i = 0; i < 16; i++) begin
         acc(1'b1, IDX_OPTIONS, {i[3], 1'b1, i[0], ~i[0], i[3], i[2:0]});
         repeat (2) @(negedge clk);
         check("tcfg", {i[0], ~i[0], i[3], i[3] ? 9'h001 : 9'h002 << i[2:0],
            i[3] ? 8'h01 << i[2:0] : 8'h01}, timerConfig);
         check("pullup", i[3] ? 8'h00 : 8'h5a, pullupEnable);
      end
      $display("options done");
   endtask : testOptions
   task automatic extStep(input logic v, input logic [7:0] e);
      @(posedge clk);
      extIrqPin <= v;
      repeat (5) @(posedge clk);
      rdChk("extflag", IDX_INTCTL, e);
      acc(1'b1, IDX_INTCTL, 8'h00);
   endtask : extStep
   task automatic irqStep(input logic [7:0] w, input logic e);
      acc(1'b1, IDX_INTCTL, w);
      repeat (2) @(negedge clk);
      check("irq", e, interruptRequest);
   endtask : irqStep
   task automatic testIrq();
      acc(1'b1, IDX_INTCTL, 8'h00);
      i_core_partner.pulse(3);
      rdChk("t0flag", IDX_INTCTL, 8'h04);
      @(negedge clk);
      check("irqmask", 1'b0, interruptRequest);
      irqStep(8'ha4, 1'b1);
      irqStep(8'h24, 1'b0);
      irqStep(8'h84, 1'b0);
      irqStep(8'h92, 1'b1);
      acc(1'b1, IDX_OPTIONS, 8'h00);
      irqStep(8'h00, 1'b0);
      extStep(1'b1, 8'h00);
      extStep(1'b0, 8'h02);
      acc(1'b1, IDX_OPTIONS, 8'h40);
      extStep(1'b1, 8'h02);
      @(posedge clk);
      portbPins <= 8'h10;
      repeat (5) @(posedge clk);
      rdChk("pbflag", IDX_INTCTL, 8'h01);
      irqStep(8'h89, 1'b1);
      @(posedge clk);
      i_core_partner.peripheralRequest <= 1'b1;
      irqStep(8'hc0, 1'b1);
      irqStep(8'h80, 1'b0);
      @(posedge clk);
      ultraLowPowerWakeup <= 1'b1;
      repeat (2) @(posedge clk);
      ultraLowPowerWakeup <= 1'b0;
      rdChk("ulpflag", IDX_INTCTL, 8'h81);
      $display("interrupts done");
   endtask : testIrq
   initial begin
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      testRegs();
      testCore();
      testOptions();
      testIrq();
      printVerdict();
   end
endmodule : core_status_option_interrupt_regs_test
bind core_status_option_interrupt_regs core_status_option_interrupt_regs_asserts i_chk (.clk, .reset_n, .read,
   .write, .address, .readdata, .waitrequest, .aluReq, .aluResult, .directBankBase, .indirectBankBase,
   .timerConfig, .pullupLatchEnables, .pullupEnable);
